// ===== logic/cmt_core.sv
// Purpose: compact timer core, 16-bit up-counter with compare A and period P, APB slave
// Assumes: all inputs synchronous to REF_CLK; clock ticks arrive as one-cycle strobes
// Notes:   zero-wait APB slave; one shared 8-bit low-byte buffer for all pairs
`timescale 1ns/1ps
`include "cmt_defines.svh"

module cmt_core (
  // clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   SYS_RST,
  // apb slave
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`CMT_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // counter clock sources
  input  wire logic                   HIGH_CLOCK_TICK,
  input  wire logic                   SUB_CLOCK_TICK,
  input  wire logic                   EXT_CLOCK_PIN,
  // output pin
  output logic                        TIMER_OUTPUT_PIN,
  output logic                        TIMER_OUTPUT_OE,
  // match events
  output logic                        MATCH_A_EVENT,
  output logic                        MATCH_P_EVENT
);

  cmt_pkg::cmt_ctrl0_t  ctrl0_r;
  cmt_pkg::cmt_ctrl1_t  ctrl1_r;
  cmt_pkg::cmt_events_t ev;
  logic [15:0]          cnt_r;
  logic [15:0]          cmpa_r;
  logic [15:0]          per_r;
  logic [7:0]           buf_r;
  logic [7:0]           rd_byte;
  logic [7:0]           pw_byte;
  logic [7:0]           cnt_lo;
  logic [7:0]           p_val;
  logic [1:0]           sys_div_r;
  logic [5:0]           h_div_r;
  logic                 on_d_r;
  logic                 ext_d_r;
  logic                 pin_r;
  logic                 ev_a_r;
  logic                 ev_p_r;
  logic                 on_rise;
  logic                 ext_rise;
  logic                 ext_fall;
  logic                 src_tick;
  logic                 tick;
  logic                 hit_a;
  logic                 hit_p;
  logic                 clr_hit;
  logic                 duty_act;
  logic                 mapped;
  logic                 wr_acc;
  logic                 rd_setup;

  assign pw_byte = PWDATA[7:0];
  assign cnt_lo  = cnt_r[7:0];
  assign p_val   = per_r[7:0];

  // apb handshake
  assign wr_acc   = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL & PENABLE & ~mapped;

  // address decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    unique case (PADDR)
      `CMT_OFS_CTRL0:   rd_byte = {ctrl0_r, 3'h0};
      `CMT_OFS_CTRL1:   rd_byte = ctrl1_r;
      `CMT_OFS_CNT_LO:  rd_byte = buf_r;
      `CMT_OFS_CNT_HI:  rd_byte = cnt_r[15:8];
      `CMT_OFS_CMPA_LO: rd_byte = buf_r;
      `CMT_OFS_CMPA_HI: rd_byte = cmpa_r[15:8];
      `CMT_OFS_PER_LO:  rd_byte = buf_r;
      `CMT_OFS_PER_HI:  rd_byte = per_r[15:8];
      `CMT_OFS_STATUS:  begin
        rd_byte[`CMT_ST_PIN] = TIMER_OUTPUT_PIN;
        rd_byte[`CMT_ST_RUN] = ctrl0_r.on & ~ctrl0_r.pause;
      end
      default:          mapped = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // control registers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl0_r <= `CMT_C0_RST;
      ctrl1_r <= `CMT_C1_RST;
    end else if (wr_acc) begin
      if (PADDR == `CMT_OFS_CTRL0) begin
        ctrl0_r <= pw_byte[7:3];
      end
      if (PADDR == `CMT_OFS_CTRL1) begin
        ctrl1_r <= pw_byte;
      end
    end
  end

  // shared low byte buffer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      buf_r <= 8'h00;
    end else if (wr_acc && (PADDR == `CMT_OFS_CMPA_LO || PADDR == `CMT_OFS_PER_LO)) begin
      buf_r <= pw_byte;
    end else if (rd_setup) begin
      unique case (PADDR)
        `CMT_OFS_CNT_HI:  buf_r <= cnt_lo;
        `CMT_OFS_CMPA_HI: buf_r <= cmpa_r[7:0];
        `CMT_OFS_PER_HI:  buf_r <= per_r[7:0];
        default:          buf_r <= buf_r;
      endcase
    end
  end

  // compare pairs: high byte write commits both halves
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cmpa_r <= 16'h0000;
      per_r  <= 16'h0000;
    end else if (wr_acc) begin
      if (PADDR == `CMT_OFS_CMPA_HI) begin
        cmpa_r <= {pw_byte, buf_r};
      end
      if (PADDR == `CMT_OFS_PER_HI) begin
        per_r <= {pw_byte, buf_r};
      end
    end
  end

  // prescalers and external edge detection
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sys_div_r <= 2'h0;
      h_div_r   <= 6'h00;
      ext_d_r   <= 1'b0;
      on_d_r    <= 1'b0;
    end else begin
      sys_div_r <= sys_div_r + 2'h1;
      if (HIGH_CLOCK_TICK) begin
        h_div_r <= h_div_r + 6'h01;
      end
      ext_d_r <= EXT_CLOCK_PIN;
      on_d_r  <= ctrl0_r.on;
    end
  end

  assign ext_rise = EXT_CLOCK_PIN & ~ext_d_r;
  assign ext_fall = ~EXT_CLOCK_PIN & ext_d_r;
  assign on_rise  = ctrl0_r.on & ~on_d_r;

  // counter clock source selection
  always_comb begin
    unique case (ctrl0_r.clk_sel)
      `CMT_CK_SYS4:     src_tick = (sys_div_r == 2'(`CMT_SYS_DIV - 1));
      `CMT_CK_SYS:      src_tick = 1'b1;
      `CMT_CK_H16:      src_tick = HIGH_CLOCK_TICK
                                   & (h_div_r[3:0] == 4'(`CMT_H_DIV_A - 1));
      `CMT_CK_H64:      src_tick = HIGH_CLOCK_TICK
                                   & (h_div_r == 6'(`CMT_H_DIV_B - 1));
      `CMT_CK_SUB0,
      `CMT_CK_SUB1:     src_tick = SUB_CLOCK_TICK;
      `CMT_CK_EXT_RISE: src_tick = ext_rise;
      `CMT_CK_EXT_FALL: src_tick = ext_fall;
    endcase
  end

  // pause freezes, off stops
  assign tick = src_tick & ctrl0_r.on & ~ctrl0_r.pause & ~on_rise;

  // comparators
  assign hit_a = (cnt_r == cmpa_r);
  assign hit_p = (cnt_r[15:8] == p_val);

  // clear source: pwm uses its period comparator, or compare A when dpx is set
  always_comb begin
    if (ctrl1_r.mode == `CMT_MODE_PWM) begin
      clr_hit = ctrl1_r.dpx ? hit_a : hit_p;
    end else begin
      clr_hit = ctrl1_r.cclr ? hit_a : hit_p;
    end
  end

  assign ev.match_a = tick & hit_a;
  assign ev.match_p = tick & hit_p;
  assign ev.ovf     = tick & (cnt_r == 16'hffff);

  // counter
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cnt_r <= `CMT_CNT_RST;
    end else if (on_rise) begin
      cnt_r <= `CMT_CNT_RST;
    end else if (tick) begin
      if (clr_hit) begin
        cnt_r <= `CMT_CNT_RST;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // events registered, one cycle after the matching tick
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ev_a_r <= 1'b0;
      ev_p_r <= 1'b0;
    end else begin
      ev_a_r <= ev.match_a;
      ev_p_r <= ev.match_p | ev.ovf;
    end
  end

  assign MATCH_A_EVENT = ev_a_r;
  assign MATCH_P_EVENT = ev_p_r;

  // pwm duty comparison
  assign duty_act = ctrl1_r.dpx ? (cnt_r[15:8] < p_val) : (cnt_r < cmpa_r);

  // output pin state
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pin_r <= 1'b0;
    end else if (on_rise) begin
      pin_r <= ctrl1_r.oc;
    end else if (ctrl0_r.on) begin
      unique case (ctrl1_r.mode)
        `CMT_MODE_CMP: begin
          if (ev.match_a) begin
            unique case (ctrl1_r.act)
              `CMT_ACT_NONE:   pin_r <= pin_r;
              `CMT_ACT_LOW:    pin_r <= 1'b0;
              `CMT_ACT_HIGH:   pin_r <= 1'b1;
              `CMT_ACT_TOGGLE: pin_r <= ~pin_r;
            endcase
          end
        end
        `CMT_MODE_PWM: begin
          unique case (ctrl1_r.act)
            `CMT_ACT_NONE:   pin_r <= ~ctrl1_r.oc;
            `CMT_ACT_LOW:    pin_r <= ctrl1_r.oc;
            `CMT_ACT_HIGH:   pin_r <= duty_act ? ctrl1_r.oc : ~ctrl1_r.oc;
            `CMT_ACT_TOGGLE: pin_r <= pin_r;
          endcase
        end
        `CMT_MODE_TMR,
        `CMT_MODE_UNDEF: pin_r <= pin_r;
      endcase
    end
  end

  assign TIMER_OUTPUT_PIN = pin_r ^ ctrl1_r.pol;
  assign TIMER_OUTPUT_OE  = ctrl0_r.on & ~ctrl1_r.mode[0];

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  a_on_rise_clears: assert property (on_rise |=> cnt_r == 16'h0000)
    else $error("counter not cleared after on rising edge");

  a_pause_freezes: assert property (ctrl0_r.pause && !on_rise |=> $stable(cnt_r))
    else $error("counter moved while paused");

  a_off_holds: assert property (!ctrl0_r.on |=> $stable(cnt_r))
    else $error("counter moved while off");

  a_match_a_pulse: assert property (tick && cnt_r == cmpa_r |=> MATCH_A_EVENT)
    else $error("compare A match gave no event");

  a_match_p_pulse: assert property (tick && cnt_r[15:8] == p_val |=> MATCH_P_EVENT)
    else $error("compare P match gave no event");

  a_no_spurious_a: assert property (!(tick && hit_a) |=> !MATCH_A_EVENT)
    else $error("compare A event without match");

  a_low_write_buf: assert property (
    wr_acc && PADDR == `CMT_OFS_CMPA_LO |=> $stable(cmpa_r) && buf_r == $past(pw_byte))
    else $error("low byte write disturbed compare A");

  a_high_write_copy: assert property (
    wr_acc && PADDR == `CMT_OFS_CMPA_HI |=> cmpa_r == {$past(pw_byte), $past(buf_r)})
    else $error("high byte write did not commit pair");

  a_high_read_latch: assert property (
    rd_setup && PADDR == `CMT_OFS_CNT_HI |=> buf_r == $past(cnt_lo))
    else $error("count high read did not latch low byte");

  a_low_read_buf: assert property (
    rd_setup && PADDR == `CMT_OFS_CNT_LO |=> PRDATA[7:0] == $past(buf_r))
    else $error("count low read did not return buffer");

  a_clear_on_match: assert property (tick && clr_hit && !on_rise |=> cnt_r == 16'h0000)
    else $error("counter not cleared on match");

  a_cmp_toggle: assert property (
    ctrl0_r.on && !on_rise && ctrl1_r.mode == `CMT_MODE_CMP
    && ctrl1_r.act == `CMT_ACT_TOGGLE && ev.match_a |=> pin_r != $past(pin_r))
    else $error("toggle action did not toggle pin");

  a_cmp_set_high: assert property (
    ctrl0_r.on && !on_rise && ctrl1_r.mode == `CMT_MODE_CMP
    && ctrl1_r.act == `CMT_ACT_HIGH && ev.match_a |=> pin_r)
    else $error("high action did not raise pin");

  a_cmp_set_low: assert property (
    ctrl0_r.on && !on_rise && ctrl1_r.mode == `CMT_MODE_CMP
    && ctrl1_r.act == `CMT_ACT_LOW && ev.match_a |=> !pin_r)
    else $error("low action did not clear pin");

  a_pin_init_level: assert property (on_rise |=> pin_r == $past(ctrl1_r.oc))
    else $error("pin not set to initial level on start");

  a_sys4_spacing: assert property (
    ctrl0_r.clk_sel == `CMT_CK_SYS4 && src_tick
    |=> !(src_tick && ctrl0_r.clk_sel == `CMT_CK_SYS4) [*3])
    else $error("system quarter clock ticked too often");

  a_ovf_wraps: assert property (
    tick && cnt_r == 16'hffff |=> cnt_r == 16'h0000 && MATCH_P_EVENT)
    else $error("overflow did not wrap with an event");

  c_cmp_match:  cover property (ctrl1_r.mode == `CMT_MODE_CMP && ev.match_a);
  c_pwm_edge:   cover property (ctrl1_r.mode == `CMT_MODE_PWM && $rose(pin_r));
  c_ext_count:  cover property (ctrl0_r.clk_sel == `CMT_CK_EXT_FALL && tick);
  c_pause_hold: cover property (ctrl0_r.on && ctrl0_r.pause [*4]);
  c_ovf_wrap:   cover property (ev.ovf);

endmodule // cmt_core

// ===== common/cmt_defines.svh
// Purpose: offsets, field positions, reset values and counts of the compact timer core
// Assumes: byte registers, each in one aligned 32-bit word of the register bus
// Notes:   definitions only
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH

`define CMT_ADDR_W       12
`define CMT_OFS_CTRL0    12'h000
`define CMT_OFS_CTRL1    12'h004
`define CMT_OFS_CNT_LO   12'h008
`define CMT_OFS_CNT_HI   12'h00c
`define CMT_OFS_CMPA_LO  12'h010
`define CMT_OFS_CMPA_HI  12'h014
`define CMT_OFS_PER_LO   12'h018
`define CMT_OFS_PER_HI   12'h01c
`define CMT_OFS_STATUS   12'h020

// control 0 fields
`define CMT_C0_PAUSE     7
`define CMT_C0_CLK_HI    6
`define CMT_C0_CLK_LO    4
`define CMT_C0_ON        3
`define CMT_C0_RST       5'h00
// control 1 fields
`define CMT_C1_MODE_HI   7
`define CMT_C1_MODE_LO   6
`define CMT_C1_ACT_HI    5
`define CMT_C1_ACT_LO    4
`define CMT_C1_OC        3
`define CMT_C1_POL       2
`define CMT_C1_DPX       1
`define CMT_C1_CCLR      0
`define CMT_C1_RST       8'h00
// status fields
`define CMT_ST_PIN       0
`define CMT_ST_RUN       1

// clock select codes
`define CMT_CK_SYS4      3'h0
`define CMT_CK_SYS       3'h1
`define CMT_CK_H16       3'h2
`define CMT_CK_H64       3'h3
`define CMT_CK_SUB0      3'h4
`define CMT_CK_SUB1      3'h5
`define CMT_CK_EXT_RISE  3'h6
`define CMT_CK_EXT_FALL  3'h7

// mode codes
`define CMT_MODE_CMP     2'h0
`define CMT_MODE_UNDEF   2'h1
`define CMT_MODE_PWM     2'h2
`define CMT_MODE_TMR     2'h3

// pin action codes
`define CMT_ACT_NONE     2'h0
`define CMT_ACT_LOW      2'h1
`define CMT_ACT_HIGH     2'h2
`define CMT_ACT_TOGGLE   2'h3

// prescale counts
`define CMT_SYS_DIV      4
`define CMT_H_DIV_A      16
`define CMT_H_DIV_B      64

`define CMT_CNT_RST      16'h0000
`endif

// ===== common/cmt_pkg.sv
// Purpose: types shared by the compact timer core
// Assumes: field order matches the control register bit order
// Notes:   constants live in cmt_defines.svh
package cmt_pkg;

  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       on;
  } cmt_ctrl0_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] act;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;
  } cmt_ctrl1_t;

  typedef struct packed {
    logic match_a;
    logic match_p;
    logic ovf;
  } cmt_events_t;

endpackage

// ===== tb/cmt_pin_src.sv
// Purpose: model of the external clock source on the timer clock input pin
// Assumes: pin changes just after REF_CLK rising edges
// Notes:   pin holds its last level between bursts
`timescale 1ns/1ps

module cmt_pin_src (
  // clock
  input  wire logic       REF_CLK,
  // burst request
  input  wire logic       GO,
  input  wire logic [3:0] TOGGLES,
  // pin side
  output logic            EXT_CLOCK_PIN,
  output logic            BUSY
);
  logic [3:0] left_r;
  logic [1:0] gap_r;

  initial begin
    EXT_CLOCK_PIN = 1'b0;
    left_r = 4'h0;
    gap_r = 2'h0;
  end

  assign BUSY = (left_r != 4'h0);

  // pin works as the timer clock input before any burst
  // pin is an input of the timer, driven only by this source
  always @(posedge REF_CLK) begin
    if (GO) begin
      left_r <= TOGGLES;
      gap_r  <= 2'h0;
    end else if (left_r != 4'h0) begin
      gap_r <= gap_r + 2'h1;
      if (gap_r == 2'h3) begin
        EXT_CLOCK_PIN <= ~EXT_CLOCK_PIN;
        left_r        <= left_r - 4'h1;
      end
    end
  end
endmodule // cmt_pin_src

// ===== tb/compact_timer_core_test.sv
// Purpose: self-checking bench for the compact timer core
// Assumes: zero-wait APB slave, byte registers in 32-bit words
// Notes:   high tick every 2 cycles, sub tick every 3 cycles
`timescale 1ns/1ps
`include "cmt_defines.svh"

module compact_timer_core_test;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        err;
  } cmt_row_t;

  logic        REF_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        HIGH_CLOCK_TICK = 1'b0;
  logic        SUB_CLOCK_TICK = 1'b0;
  logic        EXT_CLOCK_PIN;
  logic        TIMER_OUTPUT_PIN;
  logic        TIMER_OUTPUT_OE;
  logic        MATCH_A_EVENT;
  logic        MATCH_P_EVENT;
  logic        go = 1'b0;
  logic        busy;
  int          ph = 0;
  int          fails = 0;
  int          compares = 0;
  int          n;
  logic        oc;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [31:0] rdv;
  logic        errv;
  logic [3:0]  act_exp = 4'b0101;
  logic [7:0]  mode_v [4] = '{8'h9b, 8'h8b, 8'h9f, 8'hc1};
  logic [3:0]  mode_oe = 4'b0111;
  logic [3:0]  mode_pin = 4'b0001;
  int          clk_per [6] = '{40, 10, 320, 1280, 30, 30};
  // low byte before high byte on writes, high before low on reads
  cmt_row_t    rows [17] = '{
    '{0, `CMT_OFS_CTRL0, 8'h00, 8'h00, 0},
    '{0, `CMT_OFS_CTRL1, 8'h00, 8'h00, 0},
    '{0, `CMT_OFS_STATUS, 8'h00, 8'h00, 0},
    '{1, `CMT_OFS_CTRL0, 8'he7, 8'h00, 0},
    '{0, `CMT_OFS_CTRL0, 8'h00, 8'he0, 0},
    '{1, `CMT_OFS_CMPA_LO, 8'h34, 8'h00, 0},
    '{1, `CMT_OFS_CMPA_HI, 8'h12, 8'h00, 0},
    '{0, `CMT_OFS_CMPA_HI, 8'h00, 8'h12, 0},
    '{0, `CMT_OFS_CMPA_LO, 8'h00, 8'h34, 0},
    '{1, `CMT_OFS_CMPA_LO, 8'h99, 8'h00, 0},
    '{0, `CMT_OFS_CMPA_HI, 8'h00, 8'h12, 0},
    '{0, `CMT_OFS_CMPA_LO, 8'h00, 8'h34, 0},
    '{1, `CMT_OFS_PER_LO, 8'h56, 8'h00, 0},
    '{1, `CMT_OFS_PER_HI, 8'h78, 8'h00, 0},
    '{0, `CMT_OFS_PER_HI, 8'h00, 8'h78, 0},
    '{0, `CMT_OFS_PER_LO, 8'h00, 8'h56, 0},
    '{0, 12'h024, 8'h00, 8'h00, 1}};

  always #2.5 REF_CLK = ~REF_CLK;

  always @(posedge REF_CLK) begin
    ph              <= (ph == 5) ? 0 : ph + 1;
    HIGH_CLOCK_TICK <= (ph % 2 == 0);
    SUB_CLOCK_TICK  <= (ph % 3 == 0);
  end

  cmt_core u_dut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .HIGH_CLOCK_TICK(HIGH_CLOCK_TICK),
    .SUB_CLOCK_TICK(SUB_CLOCK_TICK), .EXT_CLOCK_PIN(EXT_CLOCK_PIN),
    .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_OE(TIMER_OUTPUT_OE),
    .MATCH_A_EVENT(MATCH_A_EVENT), .MATCH_P_EVENT(MATCH_P_EVENT)
  );

  cmt_pin_src u_src (
    .REF_CLK(REF_CLK), .GO(go), .TOGGLES(4'h5), .EXT_CLOCK_PIN(EXT_CLOCK_PIN),
    .BUSY(busy)
  );

  task automatic conclude;
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic timeout;
    fails++;
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= {24'h000000, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1 && k < 20) begin
      k++;
      @(posedge REF_CLK);
    end
    if (k >= 20) timeout();
    rdv = PRDATA;
    errv = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(output logic [15:0] v);
    apb(1'b0, `CMT_OFS_CNT_HI, 8'h00);
    v[15:8] = rdv[7:0];
    apb(1'b0, `CMT_OFS_CNT_LO, 8'h00);
    v[7:0] = rdv[7:0];
  endtask

  task automatic wait_ev(input logic p, output int k);
    k = 0;
    @(posedge REF_CLK);
    while ((p ? MATCH_P_EVENT : MATCH_A_EVENT) !== 1'b1 && k < 3000) begin
      k++;
      @(posedge REF_CLK);
    end
    if (k >= 3000) timeout();
  endtask

  task automatic per(input logic p, input int exp);
    int k;
    wait_ev(p, k);
    wait_ev(p, k);
    chk("event period", k + 1, exp);
  endtask

  initial begin
    repeat (4) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("reg read", rdv, {24'h0, rows[i].e});
      chk("slave error", errv, rows[i].err);
    end
    w(`CMT_OFS_CMPA_LO, 8'h09);
    w(`CMT_OFS_CMPA_HI, 8'h00);
    for (int i = 0; i < 4; i++) begin
      oc = (i != 2);
      w(`CMT_OFS_CTRL0, 8'h00);
      w(`CMT_OFS_CTRL1, {2'b00, i[1:0], oc, 3'b001});
      w(`CMT_OFS_CTRL0, 8'h18);
      repeat (2) @(posedge REF_CLK);
      #1;
      chk("pin initial", TIMER_OUTPUT_PIN, oc);
      chk("pin enable", TIMER_OUTPUT_OE, 1'b1);
      wait_ev(1'b0, n);
      #1;
      chk("pin after match", TIMER_OUTPUT_PIN, act_exp[i]);
      per(1'b0, 10);
    end
    for (int i = 0; i < 4; i++) begin
      w(`CMT_OFS_CTRL0, 8'h00);
      w(`CMT_OFS_CTRL1, mode_v[i]);
      w(`CMT_OFS_CTRL0, 8'h18);
      per(1'b0, 10);
      #1;
      chk("pin enable", TIMER_OUTPUT_OE, mode_oe[i]);
      if (mode_oe[i]) chk("pwm pin", TIMER_OUTPUT_PIN, mode_pin[i]);
    end
    w(`CMT_OFS_CTRL1, 8'h01);
    for (int i = 0; i < 6; i++) begin
      w(`CMT_OFS_CTRL0, 8'h00);
      w(`CMT_OFS_CTRL0, {1'b0, i[2:0], 4'h8});
      per(1'b0, clk_per[i]);
    end
    for (int i = 6; i < 8; i++) begin
      w(`CMT_OFS_CTRL0, 8'h00);
      w(`CMT_OFS_CTRL0, {1'b0, i[2:0], 4'h8});
      repeat (3) @(posedge REF_CLK);
      go <= 1'b1;
      @(posedge REF_CLK);
      go <= 1'b0;
      n = 0;
      @(posedge REF_CLK);
      while (busy === 1'b1 && n < 100) begin
        n++;
        @(posedge REF_CLK);
      end
      if (n >= 100) timeout();
      repeat (4) @(posedge REF_CLK);
      rdc(v1);
      chk("edge count", v1, 3);
    end
    w(`CMT_OFS_CTRL0, 8'h00);
    w(`CMT_OFS_CTRL1, 8'h00);
    w(`CMT_OFS_PER_LO, 8'h01);
    w(`CMT_OFS_PER_HI, 8'h00);
    w(`CMT_OFS_CTRL0, 8'h18);
    per(1'b1, 257);
    w(`CMT_OFS_CTRL0, 8'h00);
    w(`CMT_OFS_CTRL1, 8'ha8);
    w(`CMT_OFS_CTRL0, 8'h18);
    wait_ev(1'b1, n);
    n = 0;
    for (int i = 0; i < 257; i++) begin
      @(posedge REF_CLK);
      #1;
      n += TIMER_OUTPUT_PIN;
    end
    chk("pwm duty", n, 9);
    w(`CMT_OFS_CTRL0, 8'h10);
    rdc(v1);
    repeat (20) @(posedge REF_CLK);
    rdc(v2);
    chk("off hold", v2, v1);
    w(`CMT_OFS_CTRL0, 8'h98);
    rdc(v1);
    chk("on clear", v1, 0);
    w(`CMT_OFS_CTRL0, 8'h18);
    w(`CMT_OFS_CTRL0, 8'h98);
    rdc(v1);
    repeat (20) @(posedge REF_CLK);
    rdc(v2);
    chk("pause hold", v2, v1);
    chk("resume", (v1 > 0 && v1 < 16), 1);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    apb(1'b0, `CMT_OFS_CTRL0, 8'h00);
    chk("ctrl0 after reset", rdv, 0);
    rdc(v1);
    chk("count after reset", v1, 0);
    chk("oe after reset", TIMER_OUTPUT_OE, 0);
    conclude();
  end
endmodule // compact_timer_core_test
